// *** verilog/sram_host_pkg.sv ***
// constants and carrier types for the async sram host controller
// Contract
// - a write happens only while strobe is low, select_n low and select_p high together.
// - write data must be set up and held around the edge that actually ends the write.
// - a strobe-ended write with the gate low keeps the strobe low for setup plus float delay.
// - the host never drives the data lines while the memory drives them.
// - for a select-started read the address is valid no later than the selects go active.
package sram_host_pkg;

    localparam int CLK_PERIOD_NS   = 50;
    // timing figures of the memory, ns
    localparam int READ_CYCLE_NS   = 55;
    localparam int ADDR_TO_DATA_NS = 55;
    localparam int GATE_FLOAT_NS   = 20;
    localparam int WRITE_PULSE_NS  = 40;
    localparam int data_setup_to_write_end_NS = 25;
    localparam int strobe_low_to_float_NS     = 20;
    localparam int WRITE_PULSE_GATE_LOW_NS    =
        data_setup_to_write_end_NS + strobe_low_to_float_NS;
    localparam int DATA_HOLD_NS    = 0;
    localparam int WRITE_CYCLE_NS  = 55;

    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // read: address and gate settle before sampling
    localparam int READ_CYC   = cyc_min(ADDR_TO_DATA_NS);
    // strobe low long enough for both forms of write pulse
    localparam int WRITE_CYC  = cyc_min((WRITE_PULSE_GATE_LOW_NS > WRITE_PULSE_NS)
                                        ? WRITE_PULSE_GATE_LOW_NS : WRITE_PULSE_NS);
    // bus turnaround after the gate is released, before the host drives
    localparam int FLOAT_CYC  = cyc_min(GATE_FLOAT_NS);
    localparam int HOLD_CYC   = cyc_min(DATA_HOLD_NS);
    localparam int CNT_W      = 4;

    typedef struct packed {
        logic select_n;
        logic select_p;
        logic strobe_n;
        logic gate_n;
    } ctrl_pins_t;

    localparam ctrl_pins_t PINS_IDLE = '{select_n: 1'b1, select_p: 1'b0,
                                         strobe_n: 1'b1, gate_n: 1'b1};

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RSEL  = 3'b001,
        ST_RWAIT = 3'b010,
        ST_TURN  = 3'b011,
        ST_WSET  = 3'b100,
        ST_WLOW  = 3'b101,
        ST_WHOLD = 3'b110
    } state_t;

endpackage

// *** verilog/sram_host_ctrl.sv ***
// host side controller driving an async byte wide sram through its pins
`timescale 1ns/10ps
module sram_host_ctrl #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 8
) (
    input  wire logic              core_clk_i,
    input  wire logic              nrst_i,
    input  wire logic              req_valid_i,
    input  wire logic              req_write_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [DATA_W-1:0] req_wdata_i,
    output logic                   req_ready_o,
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_rdata_o,
    output logic [ADDR_W-1:0]      mem_addr_o,
    output logic                   select_n_o,
    output logic                   select_p_o,
    output logic                   strobe_n_o,
    output logic                   gate_n_o,
    output logic [DATA_W-1:0]      mem_dq_o,
    output logic                   mem_dq_oe_o,
    input  wire logic [DATA_W-1:0] mem_dq_i
);

    sram_host_pkg::state_t     state;
    sram_host_pkg::state_t     next_state;
    sram_host_pkg::ctrl_pins_t pins;
    sram_host_pkg::ctrl_pins_t next_pins;
    logic [sram_host_pkg::CNT_W-1:0] cnt;
    logic [sram_host_pkg::CNT_W-1:0] next_cnt;
    logic                      next_oe;

    wire logic cnt_done   = (cnt == '0);
    wire logic take_req   = (state == sram_host_pkg::ST_IDLE) && req_valid_i;
    wire logic read_end   = (state == sram_host_pkg::ST_RWAIT) && cnt_done;
    wire logic want_write = req_valid_i && req_write_i;
    wire logic want_read  = req_valid_i && !req_write_i;
    wire logic going_idle = (next_state == sram_host_pkg::ST_IDLE);

    // counters load n-1 so that a figure of n cycles spends n cycles in the state
    function automatic logic [sram_host_pkg::CNT_W-1:0] load(input int n);
        return sram_host_pkg::CNT_W'(n - 1);
    endfunction

    // the two selects always move as a pair; the gate opens only for reads
    function automatic sram_host_pkg::ctrl_pins_t sel_pins(input logic wr);
        sram_host_pkg::ctrl_pins_t p;
        p.select_n = 1'b0;
        p.select_p = 1'b1;
        p.strobe_n = !wr;
        p.gate_n   = wr;
        return p;
    endfunction

    always_comb
    begin
        next_state = state;
        next_pins  = pins;
        next_cnt   = cnt_done ? cnt : cnt - 1'b1;
        next_oe    = mem_dq_oe_o;
        case (state)
            sram_host_pkg::ST_IDLE:
            begin
                next_pins = sram_host_pkg::PINS_IDLE;
                if (want_write)
                begin
                    // address settles one cycle before the selects and strobe meet
                    next_state = sram_host_pkg::ST_WSET;
                    next_oe    = 1'b1;
                end
                else if (want_read)
                begin
                    next_state = sram_host_pkg::ST_RSEL;
                end
            end
            sram_host_pkg::ST_RSEL:
            begin
                // address has been stable a cycle when both selects and gate go active
                next_pins  = sel_pins(1'b0);
                next_cnt   = load(sram_host_pkg::READ_CYC);
                next_state = sram_host_pkg::ST_RWAIT;
            end
            sram_host_pkg::ST_RWAIT:
            begin
                if (cnt_done)
                begin
                    next_pins  = sram_host_pkg::PINS_IDLE;
                    next_cnt   = load(sram_host_pkg::FLOAT_CYC);
                    next_state = sram_host_pkg::ST_TURN;
                end
            end
            sram_host_pkg::ST_TURN:
            begin
                // memory may still drive for a while after the gate rises
                if (cnt_done)
                begin
                    next_state = sram_host_pkg::ST_IDLE;
                end
            end
            sram_host_pkg::ST_WSET:
            begin
                // gate stays high so the memory never drives during the write
                next_pins  = sel_pins(1'b1);
                next_cnt   = load(sram_host_pkg::WRITE_CYC);
                next_state = sram_host_pkg::ST_WLOW;
            end
            sram_host_pkg::ST_WLOW:
            begin
                if (cnt_done)
                begin
                    // strobe and selects end together, data still driven
                    next_pins  = sram_host_pkg::PINS_IDLE;
                    next_cnt   = load(sram_host_pkg::HOLD_CYC);
                    next_state = sram_host_pkg::ST_WHOLD;
                end
            end
            sram_host_pkg::ST_WHOLD:
            begin
                if (cnt_done)
                begin
                    next_oe    = 1'b0;
                    next_state = sram_host_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state = sram_host_pkg::ST_IDLE;
                next_pins  = sram_host_pkg::PINS_IDLE;
                next_oe    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            state <= sram_host_pkg::ST_IDLE;
            cnt   <= '0;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // pins and bus enable share one reset so the bus is released with the selects
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            pins        <= sram_host_pkg::PINS_IDLE;
            mem_dq_oe_o <= 1'b0;
        end
        else
        begin
            pins        <= next_pins;
            mem_dq_oe_o <= next_oe;
        end
    end

    // address and write data change only on a take, so they stand through the access
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            mem_addr_o <= '0;
            mem_dq_o   <= '0;
        end
        else if (take_req)
        begin
            mem_addr_o <= req_addr_i;
            mem_dq_o   <= req_wdata_i;
        end
    end

    // sampled at the edge that releases the gate, while the memory still drives
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            rsp_rdata_o <= '0;
        end
        else if (read_end)
        begin
            rsp_rdata_o <= mem_dq_i;
        end
    end

    // ready looks one state ahead so it is high while idle, except during reset and the first cycle after it
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            rsp_valid_o <= 1'b0;
            req_ready_o <= 1'b0;
        end
        else
        begin
            rsp_valid_o <= read_end;
            req_ready_o <= going_idle;
        end
    end

    assign select_n_o = pins.select_n;
    assign select_p_o = pins.select_p;
    assign strobe_n_o = pins.strobe_n;
    assign gate_n_o   = pins.gate_n;

endmodule

// *** dv/sram_host_checker.sv ***
// pin protocol assertions for the async sram host controller
`timescale 1ns/10ps
module sram_host_checker #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 8
) (
    input wire logic              core_clk_i,
    input wire logic              nrst_i,
    input wire logic              req_valid_i,
    input wire logic              req_ready_o,
    input wire logic              rsp_valid_o,
    input wire logic [DATA_W-1:0] rsp_rdata_o,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic              select_n_o,
    input wire logic              select_p_o,
    input wire logic              strobe_n_o,
    input wire logic              gate_n_o,
    input wire logic [DATA_W-1:0] mem_dq_o,
    input wire logic              mem_dq_oe_o,
    input wire logic [DATA_W-1:0] mem_dq_i
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    property p_take;
        req_valid_i && req_ready_o |=> mem_addr_o == $past(req_addr_i)
            ##1 !select_n_o && select_p_o && mem_addr_o == $past(req_addr_i, 2);
    endproperty
    a_take: assert property (p_take) else $error("select or address wrong after take");
    property p_wsel;
        !strobe_n_o |-> !select_n_o && select_p_o && gate_n_o && mem_dq_oe_o;
    endproperty
    a_wsel: assert property (p_wsel) else $error("strobe low outside a full select");
    property p_wset;
        $fell(strobe_n_o) |-> $past(mem_dq_oe_o) && $stable(mem_dq_o);
    endproperty
    a_wset: assert property (p_wset) else $error("write data not set up before strobe");
    property p_wend;
        $rose(strobe_n_o) |-> select_n_o && !select_p_o && gate_n_o;
    endproperty
    a_wend: assert property (p_wend) else $error("write end not on all pins together");
    property p_whold;
        $rose(strobe_n_o) |-> mem_dq_oe_o && $stable(mem_dq_o);
    endproperty
    a_whold: assert property (p_whold) else $error("write data not held after end");
    property p_nofight;
        mem_dq_oe_o |-> gate_n_o;
    endproperty
    a_nofight: assert property (p_nofight) else $error("host drives while gate open");
    property p_read;
        $fell(gate_n_o) |-> (strobe_n_o && !mem_dq_oe_o && !select_n_o && !gate_n_o)[*2]
            ##1 gate_n_o;
    endproperty
    a_read: assert property (p_read) else $error("read window shape wrong");
    property p_rsp;
        $rose(gate_n_o) |-> rsp_valid_o && rsp_rdata_o == $past(mem_dq_i);
    endproperty
    a_rsp: assert property (p_rsp) else $error("read data not taken at gate release");
endmodule
bind sram_host_ctrl sram_host_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (
    .core_clk_i, .nrst_i, .req_valid_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o,
    .req_addr_i, .mem_addr_o, .select_n_o, .select_p_o, .strobe_n_o, .gate_n_o,
    .mem_dq_o, .mem_dq_oe_o, .mem_dq_i);

// *** dv/sram_model.sv ***
// behavioural byte wide async static memory seen from the host pins
`timescale 1ns/10ps
module sram_model #(
    parameter int AW     = 21,
    parameter int DLY_NS = 55
) (
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          select_n_i,
    input  wire logic          select_p_i,
    input  wire logic          strobe_n_i,
    input  wire logic          gate_n_i,
    input  wire logic [7:0]    dq_i,
    output logic [7:0]         dq_o,
    output logic               drive_o
);
    logic [7:0] mem [0:(1<<AW)-1]; // unwritten bytes read as unknown
    logic [7:0] last = 8'h00;
    logic [7:0] next_dq;
    wire        sel = !select_n_i && select_p_i;
    wire        wr  = sel && !strobe_n_i;
    assign drive_o = sel && strobe_n_i && !gate_n_i;
    // the write lands when the overlap closes, whichever pin ends it
    always @(negedge wr)
        if (^addr_i !== 1'bx)
            mem[addr_i] = dq_i;
    // writes and reads never overlap in time, so the array is left off the list
    always @(drive_o or addr_i or last)
        if (drive_o)
            next_dq = mem[addr_i];
        else
            next_dq = ~last; // a released bus must not keep showing the old byte
    always @(drive_o or next_dq)
        if (drive_o)
            last = next_dq;
    assign #(DLY_NS) dq_o = next_dq;
endmodule

// *** dv/test_async_sram_byte_port_control.sv ***
// self-checking bench for the async sram host controller
`timescale 1ns/10ps
module test_async_sram_byte_port_control;
    logic        core_clk_i  = 1'h0;
    logic        nrst_i      = 1'h0;
    logic        req_valid_i = 1'h0;
    logic        req_write_i = 1'h0;
    logic [20:0] req_addr_i  = 21'h0;
    logic [7:0]  req_wdata_i = 8'h00;
    logic        req_ready_o, rsp_valid_o, select_n_o, select_p_o;
    logic        strobe_n_o, gate_n_o, mem_dq_oe_o, mem_drive;
    logic [20:0] mem_addr_o;
    logic [7:0]  rsp_rdata_o, mem_dq_o, mem_out;
    wire  [7:0]  mem_dq_i = mem_dq_oe_o ? mem_dq_o : mem_out;
    int          n_errors, cmp_count;
    sram_host_ctrl DUT (.core_clk_i, .nrst_i, .req_valid_i, .req_write_i, .req_addr_i,
        .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .mem_addr_o, .select_n_o,
        .select_p_o, .strobe_n_o, .gate_n_o, .mem_dq_o, .mem_dq_oe_o, .mem_dq_i);
    sram_model mem (.addr_i(mem_addr_o), .select_n_i(select_n_o), .select_p_i(select_p_o),
        .strobe_n_i(strobe_n_o), .gate_n_i(gate_n_o), .dq_i(mem_dq_i), .dq_o(mem_out),
        .drive_o(mem_drive));
    always #25 core_clk_i = ~core_clk_i;
    // the memory and the host must never drive the data lines at once
    always @(negedge core_clk_i)
        if (nrst_i && mem_drive && mem_dq_oe_o)
        begin
            n_errors++;
            $display("BAD contention expected 0 seen 1");
        end
    task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic req(input logic w, input logic [20:0] a, input logic [7:0] d);
        for (int i = 0; i < 20 && req_ready_o !== 1'h1; i++)
            @(negedge core_clk_i);
        chk("ready before request", 21'h1, {20'h0, req_ready_o});
        req_valid_i = 1'h1;
        req_write_i = w;
        req_addr_i  = a;
        req_wdata_i = d;
        @(negedge core_clk_i);
        req_valid_i = 1'h0;
    endtask
    task automatic rd(input logic [20:0] a, input logic [7:0] e);
        req(1'h0, a, 8'h00);
        repeat (3) @(negedge core_clk_i);
        chk("rsp_valid", 21'h1, {20'h0, rsp_valid_o});
        chk("rdata", {13'h0, e}, {13'h0, rsp_rdata_o});
    endtask
    task automatic t_idle;
        chk("idle pins", 21'h16, {16'h0, select_n_o, select_p_o, strobe_n_o, gate_n_o,
            mem_dq_oe_o});
        chk("ready", 21'h1, {20'h0, req_ready_o});
        $display("test idle done");
    endtask
    task automatic t_rw;
        logic [20:0] a[3] = '{21'h0, 21'h1FFFFF, 21'h0AAAAA};
        logic [7:0]  d[3] = '{8'hA5, 8'h5A, 8'h3C};
        for (int i = 0; i < 3; i++)
            req(1'h1, a[i], d[i]);
        for (int i = 2; i >= 0; i--)
            rd(a[i], d[i]);
        $display("test write read done");
    endtask
    task automatic t_refuse;
        req(1'h1, 21'h10, 8'h12);
        @(negedge core_clk_i);
        req_valid_i = 1'h1;
        req_wdata_i = 8'h77;
        chk("ready busy", 21'h0, {20'h0, req_ready_o});
        @(negedge core_clk_i);
        req_valid_i = 1'h0;
        rd(21'h10, 8'h12);
        $display("test refuse done");
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        // whole run is about 56 cycles, so 400 cycles means a hang
        #20000;
        n_errors++;
        final_report;
    end
    initial
    begin
        repeat (20) @(negedge core_clk_i);
        nrst_i = 1'h1;
        @(negedge core_clk_i);
        t_idle;
        t_rw;
        t_refuse;
        final_report;
    end
endmodule
